// ---- core/sdmlc_pkg.sv ----
package sdmlc_pkg;
  // ==========================================================================
  // register indices (word offsets, byte address = 4 x index)
  // ==========================================================================
  localparam logic [7:0] REG_CLOCK = 8'h00;  // operating mode, prescaler
  localparam logic [7:0] REG_SPDIF = 8'h01;  // auto-mute bypass, lock override
  localparam logic [7:0] REG_FEAT = 8'h02;   // filter mode, de-emphasis, rates
  localparam logic [7:0] REG_VOL = 8'h03;    // left / right volume
  localparam logic [7:0] REG_TONE = 8'h04;   // bass, treble
  localparam logic [7:0] REG_MUTE = 8'h13;   // soft mute bit
  localparam logic [7:0] REG_STAT = 8'h20;   // lock, pcm, mute state
  localparam logic [7:0] REG_LEFT = 8'h21;   // left audio word
  localparam logic [7:0] REG_RIGHT = 8'h22;  // right audio word
  localparam logic [7:0] REG_CSL0 = 8'h23;   // left channel status [31:0]
  localparam logic [7:0] REG_CSL1 = 8'h24;   // left channel status [39:32]
  localparam logic [7:0] REG_CSR0 = 8'h25;
  localparam logic [7:0] REG_CSR1 = 8'h26;
  // ==========================================================================
  // field positions and reset values
  // ==========================================================================
  localparam int SPDIF_BYPASS_BIT = 0;
  localparam int SPDIF_OVR_EN_BIT = 1;
  localparam int SPDIF_OVR_VAL_BIT = 2;
  localparam logic [3:0] MODE_XTAL_DAC = 4'h6;
  localparam logic [3:0] MODE_SPLIT = 4'h7;
  localparam logic [3:0] MODE_SYNTH = 4'h8;
  localparam logic [3:0] RST_MODE = 4'h1;
  localparam logic [7:0] RST_PRESCALE = 8'h04;
  localparam logic RST_SOFT_MUTE = 1'b1;
  localparam int SAMPLE_W = 24;
  localparam int CS_W = 40;
  // soft mute ramp: 32 x 32 samples, about 23 ms at 44.1 kHz
  localparam int RAMP_SAMPLES = 32 * 32;
  localparam int RAMP_W = 10;
  localparam int CLK_MHZ = 125;

  typedef enum logic [1:0] {
    SDMLC_FMT_I2S, SDMLC_FMT_LSB16, SDMLC_FMT_LSB20, SDMLC_FMT_LSB24
  } sdmlc_fmt_t;
  typedef enum logic [1:0] {
    SDMLC_CTL_BUS3, SDMLC_CTL_I2C, SDMLC_CTL_STATIC
  } sdmlc_ctl_t;
  typedef enum logic [1:0] {
    SDMLC_FILT_FLAT, SDMLC_FILT_MIN, SDMLC_FILT_MAX
  } sdmlc_filt_t;
  typedef enum logic [1:0] {
    SDMLC_DEEMP_OFF, SDMLC_DEEMP_32K, SDMLC_DEEMP_44K, SDMLC_DEEMP_48K
  } sdmlc_deemp_t;

  // decoded sample from the front end
  typedef struct packed {
    logic valid;
    logic right;
    logic [SAMPLE_W-1:0] data;
  } sdmlc_sample_t;

  // routing decisions for the clock tree and data path
  typedef struct packed {
    logic dac_from_xtal;
    logic in_slave;
    logic pll_to_spdif;
    logic out_data_valid;
    logic xtal_out_en;
    logic [7:0] prescale;
  } sdmlc_route_t;

  // audio feature settings handed to the dsp
  typedef struct packed {
    logic [7:0] vol_l;
    logic [7:0] vol_r;
    logic [3:0] bass;
    logic [3:0] treble;
    sdmlc_filt_t filt;
    sdmlc_deemp_t deemp;
    logic os128;
    sdmlc_fmt_t fmt;
  } sdmlc_feat_t;
endpackage

// ---- core/sdmlc_ramp.sv ----
`timescale 1ns/100ps
// raised-cosine gain ramp, one step per sample, gain read from a register
module sdmlc_ramp #(
  parameter int STEPS = 1024
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // control
  input wire logic mute_req,
  input wire logic step,
  // gain out
  output logic [15:0] gain,
  output logic at_zero
);
  localparam int LW = $clog2(STEPS);
  initial begin
    if (STEPS < 4 || (1 << LW) != STEPS) begin
      $error("ramp steps must be a power of two");
    end
  end
  // ==========================================================================
  // cosine table, computed at elaboration
  // ==========================================================================
  typedef struct packed {
    logic [LW:0] pos;
    logic [15:0] gain;
  } sdmlc_ramp_st_t;
  sdmlc_ramp_st_t st_q, st_d;
  logic [15:0] table_m [0:STEPS];
  // the table is a fixed constant, no file is read
  function automatic logic [15:0] cosval(input int i);
    real x;
    x = 3.14159265358979 * i / STEPS;
    return 16'(int'(32767.0 * (1.0 - $cos(x))));
  endfunction
  genvar g;
  generate
    for (g = 0; g <= STEPS; g++) begin : g_tab
      assign table_m[g] = cosval(g);
    end
  endgenerate
  // move one step toward the target each sample; mid-ramp reversal is smooth
  always_comb begin
    st_d = st_q;
    if (step && mute_req && st_q.pos != '0) begin
      st_d.pos = st_q.pos - 1'b1;
    end else if (step && !mute_req && st_q.pos != (LW+1)'(STEPS)) begin
      st_d.pos = st_q.pos + 1'b1;
    end
    st_d.gain = table_m[st_d.pos];
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign gain = st_q.gain;
  assign at_zero = (st_q.pos == '0);
endmodule // sdmlc_ramp

// ---- core/sdmlc_top.sv ----
`timescale 1ns/100ps
// Behaviour
// - mode 6: dac on crystal clock, input port slave to external bit clock
// - mode 7: output path locks spdif, dac on crystal, source stays synchronous
// - mode 8: crystal feeds spdif, pll makes output clocks by prescaler, data invalid
// - pll lock bit set on lock, readable by software
// - lock pin high only when decoder and clock locked and pcm
// - software bits can override the combined lock pin
// - pcm detect pin high while valid pcm is detected
// - crystal clock usable internally and drivable to oscillator pin
// - mute pin or bit gives raised-cosine soft mute of 1024 samples
// - serial modes start muted; only writing zero to soft mute releases
// - mute pin high always mutes, in every control mode
// - hard mute until locked, abrupt, ignores pin and bit
// - bypass bit at index 01 stops out-of-lock muting
// - 24-bit audio and 40 status bits per channel readable
// - accepts 32, 44.1 and 48 kHz rates
// - static mode always applies fixed 44.1 kHz de-emphasis
// - serial modes: volume, bass, treble, filter modes, selectable de-emphasis
// - interpolator rate 64 or 128 fs
// - noise shaper rate 64 or 128 fs, one-bit output
// - static and serial exclusive; static format from bus pins
// - format pins 00 i2s, 01 lsb16, 10 lsb20, 11 lsb24
// - serial start-up mute governed only by bit at index 13
module sdmlc_top #(
  parameter int RAMP_STEPS = sdmlc_pkg::RAMP_SAMPLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // straps and pins (asynchronous)
  input wire logic static_control_select,
  input wire logic i2c_control_select,
  input wire logic bus_mode_pin,
  input wire logic bus_data_pin,
  input wire logic mute_pin,
  input wire logic input_bit_clock,
  input wire logic input_word_select,
  // decoder front end status (same clock)
  input wire logic pll_locked,
  input wire logic dec_locked,
  input wire logic pcm_valid,
  input wire logic burst_preamble,
  input wire sdmlc_pkg::sdmlc_sample_t dec_sample,
  input wire logic [sdmlc_pkg::CS_W-1:0] cs_left,
  input wire logic [sdmlc_pkg::CS_W-1:0] cs_right,
  input wire logic xtal_clk_en,
  // status pins
  output logic lock_out,
  output logic pcm_detect_out,
  output logic crystal_clock_out,
  // to clock tree and dsp
  output sdmlc_pkg::sdmlc_route_t route,
  output sdmlc_pkg::sdmlc_feat_t feat,
  output sdmlc_pkg::sdmlc_ctl_t ctl_mode,
  output logic [15:0] dsp_gain,
  output logic hard_mute,
  output logic in_frame_strobe
);
  initial begin
    // shorter power-of-two ramps serve only to shorten simulation
    if (RAMP_STEPS < 4 || (RAMP_STEPS & (RAMP_STEPS - 1)) != 0) begin
      $error("ramp length must be a power of two, four or more");
    end
  end
  // ==========================================================================
  // state
  // ==========================================================================
  typedef struct packed {
    logic [1:0] s_st;
    logic [1:0] s_mute;
    logic [1:0] s_bm;
    logic [1:0] s_bd;
    logic [1:0] s_mp;
    logic [2:0] s_bck;
    logic [1:0] s_ws;
    logic ws_last;
    logic [1:0] fill;
    logic strap_done;
    sdmlc_pkg::sdmlc_ctl_t ctl;
    sdmlc_pkg::sdmlc_fmt_t fmt;
    logic [3:0] mode;
    logic [7:0] prescale;
    logic bypass;
    logic ovr_en;
    logic ovr_val;
    logic soft_mute;
    logic [31:0] feat_w;
    logic [15:0] vol_w;
    logic [7:0] tone_w;
    logic [23:0] left;
    logic [23:0] right;
    logic pll_lock_seen;
    logic lock_o;
    logic pcm_o;
    logic [31:0] rdata;
  } sdmlc_st_t;
  sdmlc_st_t st_q, st_d;
  logic ramp_zero;
  logic [15:0] ramp_gain;
  logic mute_req;
  logic serial;
  logic combined;
  // ==========================================================================
  // next state
  // ==========================================================================
  always_comb begin
    st_d = st_q;
    // two-stage synchronisers; the second stage feeds logic, and a third bit clock stage feeds its edge detect
    st_d.s_st = {st_q.s_st[0], static_control_select};
    st_d.s_mute = {st_q.s_mute[0], i2c_control_select};
    st_d.s_bm = {st_q.s_bm[0], bus_mode_pin};
    st_d.s_bd = {st_q.s_bd[0], bus_data_pin};
    st_d.s_mp = {st_q.s_mp[0], mute_pin};
    st_d.s_bck = {st_q.s_bck[1:0], input_bit_clock};
    st_d.s_ws = {st_q.s_ws[0], input_word_select};
    // word select as it stood at the last bit clock rise; it moves on the fall
    if (st_q.s_bck[1] && !st_q.s_bck[2]) begin
      st_d.ws_last = st_q.s_ws[1];
    end
    // strap capture: taken once, third edge after release, synchronisers full
    if (!st_q.strap_done) begin
      st_d.fill = st_q.fill + 2'h1;
    end
    if (!st_q.strap_done && st_q.fill == 2'h2) begin
      st_d.strap_done = 1'b1;
      if (st_q.s_st[1]) begin
        st_d.ctl = sdmlc_pkg::SDMLC_CTL_STATIC;
      end else if (st_q.s_mute[1]) begin
        st_d.ctl = sdmlc_pkg::SDMLC_CTL_I2C;
      end else begin
        st_d.ctl = sdmlc_pkg::SDMLC_CTL_BUS3;
      end
    end
    // format from the bus pins in static mode
    if (st_q.ctl == sdmlc_pkg::SDMLC_CTL_STATIC) begin
      st_d.fmt = sdmlc_pkg::sdmlc_fmt_t'({st_q.s_bm[1], st_q.s_bd[1]});
    end
    // register writes only in serial control modes
    if (reg_wr && st_q.ctl != sdmlc_pkg::SDMLC_CTL_STATIC && st_q.strap_done) begin
      if (reg_addr == sdmlc_pkg::REG_CLOCK) begin
        st_d.mode = reg_wdata[3:0];
        st_d.prescale = reg_wdata[15:8];
        st_d.fmt = sdmlc_pkg::sdmlc_fmt_t'(reg_wdata[17:16]);
      end else if (reg_addr == sdmlc_pkg::REG_SPDIF) begin
        st_d.bypass = reg_wdata[sdmlc_pkg::SPDIF_BYPASS_BIT];
        st_d.ovr_en = reg_wdata[sdmlc_pkg::SPDIF_OVR_EN_BIT];
        st_d.ovr_val = reg_wdata[sdmlc_pkg::SPDIF_OVR_VAL_BIT];
      end else if (reg_addr == sdmlc_pkg::REG_FEAT) begin
        st_d.feat_w = reg_wdata;
      end else if (reg_addr == sdmlc_pkg::REG_VOL) begin
        st_d.vol_w = reg_wdata[15:0];
      end else if (reg_addr == sdmlc_pkg::REG_TONE) begin
        st_d.tone_w = reg_wdata[7:0];
      end else if (reg_addr == sdmlc_pkg::REG_MUTE) begin
        // only a write of zero here releases start-up mute
        st_d.soft_mute = reg_wdata[0];
      end
    end
    // capture decoded audio words per channel
    if (dec_sample.valid && dec_sample.right) begin
      st_d.right = dec_sample.data;
    end else if (dec_sample.valid) begin
      st_d.left = dec_sample.data;
    end
    // sticky lock bit; a new lock beats the read-clear in the same cycle
    if (reg_rd && reg_addr == sdmlc_pkg::REG_STAT) begin
      st_d.pll_lock_seen = 1'b0;
    end
    if (pll_locked) begin
      st_d.pll_lock_seen = 1'b1;
    end
    st_d.lock_o = st_q.ovr_en ? st_q.ovr_val : combined;
    st_d.pcm_o = pcm_valid && !burst_preamble;
    // read data, stands only in the cycle after the strobe
    st_d.rdata = '0;
    if (reg_rd) begin
      if (reg_addr == sdmlc_pkg::REG_CLOCK) begin
        st_d.rdata = {14'h0000, st_q.fmt, st_q.prescale, 4'h0, st_q.mode};
      end else if (reg_addr == sdmlc_pkg::REG_SPDIF) begin
        st_d.rdata = {29'h00000000, st_q.ovr_val, st_q.ovr_en, st_q.bypass};
      end else if (reg_addr == sdmlc_pkg::REG_FEAT) begin
        st_d.rdata = st_q.feat_w;
      end else if (reg_addr == sdmlc_pkg::REG_VOL) begin
        st_d.rdata = {16'h0000, st_q.vol_w};
      end else if (reg_addr == sdmlc_pkg::REG_TONE) begin
        st_d.rdata = {24'h000000, st_q.tone_w};
      end else if (reg_addr == sdmlc_pkg::REG_MUTE) begin
        st_d.rdata = {31'h00000000, st_q.soft_mute};
      end else if (reg_addr == sdmlc_pkg::REG_STAT) begin
        st_d.rdata = {24'h000000, 1'b0, ramp_zero, hard_mute, st_q.pcm_o,
                      st_q.lock_o, dec_locked, pll_locked, st_q.pll_lock_seen};
      end else if (reg_addr == sdmlc_pkg::REG_LEFT) begin
        st_d.rdata = {8'h00, st_q.left};
      end else if (reg_addr == sdmlc_pkg::REG_RIGHT) begin
        st_d.rdata = {8'h00, st_q.right};
      end else if (reg_addr == sdmlc_pkg::REG_CSL0) begin
        st_d.rdata = cs_left[31:0];
      end else if (reg_addr == sdmlc_pkg::REG_CSL1) begin
        st_d.rdata = {24'h000000, cs_left[39:32]};
      end else if (reg_addr == sdmlc_pkg::REG_CSR0) begin
        st_d.rdata = cs_right[31:0];
      end else if (reg_addr == sdmlc_pkg::REG_CSR1) begin
        st_d.rdata = {24'h000000, cs_right[39:32]};
      end
    end
  end
  // ==========================================================================
  // registers
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= '0;
      st_q.mode <= sdmlc_pkg::RST_MODE;
      st_q.prescale <= sdmlc_pkg::RST_PRESCALE;
      st_q.soft_mute <= sdmlc_pkg::RST_SOFT_MUTE;
    end else begin
      st_q <= st_d;
    end
  end
  // ==========================================================================
  // mute and lock combinations
  // ==========================================================================
  assign serial = (st_q.ctl != sdmlc_pkg::SDMLC_CTL_STATIC);
  // combined lock needs both locks and clean pcm
  assign combined = pll_locked && dec_locked && pcm_valid && !burst_preamble;
  // pin always mutes; bit only counts in serial modes
  assign mute_req = st_q.s_mp[1] || (serial && st_q.soft_mute) || !st_q.strap_done;
  // abrupt mute until lock unless bypassed
  assign hard_mute = !st_q.bypass && !(pll_locked && dec_locked);
  // one step per decoded sample pair, so every accepted rate gets the same count
  sdmlc_ramp #(
    .STEPS(RAMP_STEPS)
  ) u_ramp (
    .clk(clk),
    .srst(srst),
    .mute_req(mute_req),
    .step(dec_sample.valid && dec_sample.right),
    .gain(ramp_gain),
    .at_zero(ramp_zero)
  );
  assign dsp_gain = hard_mute ? 16'h0000 : ramp_gain;
  // ==========================================================================
  // routing per operating mode
  // ==========================================================================
  always_comb begin
    route = '0;
    route.prescale = st_q.prescale;
    route.out_data_valid = 1'b1;
    // crystal clock to pin in synthesis mode
    route.xtal_out_en = (st_q.mode == sdmlc_pkg::MODE_SYNTH);
    if (st_q.mode == sdmlc_pkg::MODE_XTAL_DAC) begin
      route.dac_from_xtal = 1'b1;
      route.in_slave = 1'b1;
    end else if (st_q.mode == sdmlc_pkg::MODE_SPLIT) begin
      // output locked to spdif, dac on crystal
      route.dac_from_xtal = 1'b1;
      route.in_slave = 1'b1;
      route.pll_to_spdif = 1'b1;
    end else if (st_q.mode == sdmlc_pkg::MODE_SYNTH) begin
      // pll regenerates output clocks, data invalid
      route.pll_to_spdif = 1'b1;
      route.in_slave = 1'b1;
      route.out_data_valid = 1'b0;
    end
  end
  // feature settings to dsp, interpolator and shaper
  always_comb begin
    feat = '0;
    feat.fmt = st_q.fmt;
    if (serial) begin
      feat.vol_l = st_q.vol_w[7:0];
      feat.vol_r = st_q.vol_w[15:8];
      feat.bass = st_q.tone_w[3:0];
      feat.treble = st_q.tone_w[7:4];
      feat.filt = (st_q.feat_w[1:0] == 2'h3) ? sdmlc_pkg::SDMLC_FILT_MAX :
                  sdmlc_pkg::sdmlc_filt_t'(st_q.feat_w[1:0]);
      feat.deemp = sdmlc_pkg::sdmlc_deemp_t'(st_q.feat_w[3:2]);
      feat.os128 = st_q.feat_w[4];
    end else begin
      // static mode: de-emphasis fixed at 44.1, whatever the stream carries
      feat.deemp = sdmlc_pkg::SDMLC_DEEMP_44K;
    end
  end
  // crystal enable routed to the oscillator pin, in synthesis mode only
  assign crystal_clock_out = route.xtal_out_en && xtal_clk_en;
  assign lock_out = st_q.lock_o;
  assign pcm_detect_out = st_q.pcm_o;
  assign reg_rdata = st_q.rdata;
  assign ctl_mode = st_q.ctl;
  // word select edge on sampled slave clock
  assign in_frame_strobe = st_q.s_bck[1] && !st_q.s_bck[2] && (st_q.s_ws[1] != st_q.ws_last);
  // ==========================================================================
  // checks
  // ==========================================================================
  a_lock_pin_default: assert property (@(posedge clk) disable iff (srst)
    !st_q.ovr_en ##1 !st_q.ovr_en |-> lock_out == $past(combined))
    else $error("lock pin mismatch");
  a_lock_override: assert property (@(posedge clk) disable iff (srst)
    st_q.ovr_en ##1 st_q.ovr_en |-> lock_out == $past(st_q.ovr_val))
    else $error("lock override ignored");
  a_pcm_pin: assert property (@(posedge clk) disable iff (srst)
    pcm_valid && !burst_preamble |=> pcm_detect_out)
    else $error("pcm pin low");
  a_hard_mute: assert property (@(posedge clk) disable iff (srst)
    !st_q.bypass && !pll_locked |-> dsp_gain == 16'h0000)
    else $error("unlocked output not muted");
  a_mute_pin_ramps: assert property (@(posedge clk) disable iff (srst)
    st_q.s_mp[1] && dec_sample.valid && dec_sample.right && !ramp_zero |=> $past(ramp_gain) >= ramp_gain)
    else $error("mute pin did not ramp down");
  a_start_muted: assert property (@(posedge clk) disable iff (srst)
    serial && st_q.soft_mute |=> ramp_gain <= $past(ramp_gain))
    else $error("start-up mute lost");
  a_unmute_rises: assert property (@(posedge clk) disable iff (srst)
    !mute_req && dec_sample.valid && dec_sample.right |=> ramp_gain >= $past(ramp_gain))
    else $error("unmute ramp fell");
  a_ctl_frozen: assert property (@(posedge clk) disable iff (srst)
    st_q.strap_done |=> $stable(ctl_mode))
    else $error("control mode changed after capture");
  a_static_write: assert property (@(posedge clk) disable iff (srst)
    reg_wr && ctl_mode == sdmlc_pkg::SDMLC_CTL_STATIC |=> $stable({st_q.mode, st_q.soft_mute}))
    else $error("write taken in static mode");
  a_synth_invalid: assert property (@(posedge clk) disable iff (srst)
    st_q.mode == sdmlc_pkg::MODE_SYNTH |-> !route.out_data_valid && route.xtal_out_en)
    else $error("synth mode routing");
  a_xtal_dac: assert property (@(posedge clk) disable iff (srst)
    st_q.mode == sdmlc_pkg::MODE_XTAL_DAC |-> route.dac_from_xtal && route.in_slave)
    else $error("mode six routing");
  a_lock_sticky: assert property (@(posedge clk) disable iff (srst)
    pll_locked |=> st_q.pll_lock_seen)
    else $error("lock bit not set");
  c_unmute: cover property (@(posedge clk) disable iff (srst) $fell(st_q.soft_mute));
  c_lock_up: cover property (@(posedge clk) disable iff (srst) $rose(lock_out));
  c_ramp_low: cover property (@(posedge clk) disable iff (srst) $rose(ramp_zero));
endmodule // sdmlc_top

// ---- bench/sdmlc_dsp_model.sv ----
`timescale 1ns/100ps
// ==========================================================================
// serial audio source standing in for the external dsp
// ==========================================================================
module sdmlc_dsp_model (
  // frame control
  input wire logic run,
  // serial clocks to the device
  output logic bck,
  output logic ws
);
  int bits;
  initial begin
    bck = 1'b0;
    ws = 1'b0;
    bits = 0;
  end
  // one shared timebase
  // bit clock stands still outside frames, word select flips every 32 bits
  always begin
    #80;
    if (run) begin
      bck = ~bck;
      if (!bck) begin
        bits = (bits + 1) % 32;
        if (bits == 0) ws = ~ws;
      end
    end
  end
endmodule // sdmlc_dsp_model

// ---- bench/tb_sdmlc_top.sv ----
`timescale 1ns/100ps
// ==========================================================================
// bench for mute, lock, mode and control selection
// ==========================================================================
module tb_sdmlc_top;
  localparam int STEPS = 8; // short ramp keeps the run brief
  logic clk, srst, reg_wr, reg_rd, st_sel, i2c_sel, bmode, bdata, mute_pin, run;
  logic pll, dec, pcm, burst, xen, bck, ws, lock_out, pcm_det, xout, hmute, strobe;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd_val;
  logic [39:0] csl, csr;
  logic [15:0] gain, g_full;
  sdmlc_pkg::sdmlc_sample_t smp;
  sdmlc_pkg::sdmlc_route_t route;
  sdmlc_pkg::sdmlc_feat_t feat;
  sdmlc_pkg::sdmlc_ctl_t ctl;
  int err_count, n_compared, strobes;

  sdmlc_top #(.RAMP_STEPS(STEPS)) dut (.clk(clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .static_control_select(st_sel), .i2c_control_select(i2c_sel), .bus_mode_pin(bmode),
    .bus_data_pin(bdata), .mute_pin(mute_pin), .input_bit_clock(bck),
    .input_word_select(ws), .pll_locked(pll), .dec_locked(dec), .pcm_valid(pcm),
    .burst_preamble(burst), .dec_sample(smp), .cs_left(csl), .cs_right(csr),
    .xtal_clk_en(xen), .lock_out(lock_out), .pcm_detect_out(pcm_det),
    .crystal_clock_out(xout), .route(route), .feat(feat), .ctl_mode(ctl),
    .dsp_gain(gain), .hard_mute(hmute), .in_frame_strobe(strobe));
  sdmlc_dsp_model dsp (.run(run), .bck(bck), .ws(ws));

  // ==========================================================================
  // clock, strobe counter and shared tasks
  // ==========================================================================
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) if (strobe === 1'b1) strobes++;
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask
  task automatic feed(input logic r, input logic [23:0] d, input int n);
    repeat (n) begin
      @(posedge clk);
      smp <= {1'b1, r, d};
      @(posedge clk);
      smp.valid <= 1'b0;
    end
    #1;
  endtask
  task automatic do_reset(input logic s, input logic i);
    st_sel <= s;
    i2c_sel <= i;
    srst <= 1'b1;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    cyc(4);
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // scenarios
  // ==========================================================================
  task automatic t_lock();
    rd(sdmlc_pkg::REG_MUTE);
    cmp(32'(rd_val[0]), 32'h1);
    rd(8'hFE);
    cmp(rd_val, 32'h0);
    pll <= 1'b1;
    dec <= 1'b1;
    pcm <= 1'b1;
    cyc(3);
    cmp({lock_out, pcm_det}, 32'h3);
    rd(sdmlc_pkg::REG_STAT);
    cmp(32'(rd_val[1:0]), 32'h3);
    burst <= 1'b1;
    cyc(3);
    cmp({lock_out, pcm_det}, 32'h0);
    burst <= 1'b0;
    wr(sdmlc_pkg::REG_SPDIF, 32'h0000_0002);
    cyc(2);
    cmp(32'(lock_out), 32'h0);
    wr(sdmlc_pkg::REG_SPDIF, 32'h0000_0006);
    dec <= 1'b0;
    cyc(2);
    cmp(32'(lock_out), 32'h1);
    wr(sdmlc_pkg::REG_SPDIF, 32'h0000_0000);
    dec <= 1'b1;
    feed(1'b1, 24'h123456, STEPS + 2);
    cmp(32'(gain), 32'h0);
  endtask
  task automatic t_hard();
    pll <= 1'b0;
    cyc(1);
    cmp({hmute, gain}, 32'h1_0000);
    wr(sdmlc_pkg::REG_SPDIF, 32'h0000_0001);
    cmp(32'(hmute), 32'h0);
    wr(sdmlc_pkg::REG_SPDIF, 32'h0000_0000);
    pll <= 1'b1;
    cyc(1);
  endtask
  task automatic t_ramp();
    wr(sdmlc_pkg::REG_MUTE, 32'h0);
    feed(1'b1, 24'h0, STEPS + 2);
    g_full = gain;
    cmp(32'(gain == 16'h0000), 32'h0);
    mute_pin <= 1'b1;
    cyc(4);
    feed(1'b1, 24'h0, STEPS / 2);
    cmp(32'(gain != 16'h0000 && gain < g_full), 32'h1);
    feed(1'b1, 24'h0, STEPS);
    cmp(32'(gain), 32'h0);
    rd(sdmlc_pkg::REG_STAT);
    cmp(32'(rd_val[6]), 32'h1);
    mute_pin <= 1'b0;
  endtask
  task automatic t_data();
    csl <= 40'hC1_8421_7E3D;
    csr <= 40'h3E_7C5A_9B12;
    feed(1'b0, 24'hA5C37E, 1);
    feed(1'b1, 24'h5A3C81, 1);
    rd(sdmlc_pkg::REG_LEFT);
    cmp(rd_val, 32'h00A5_C37E);
    rd(sdmlc_pkg::REG_RIGHT);
    cmp(rd_val, 32'h005A_3C81);
    rd(sdmlc_pkg::REG_CSL0);
    cmp(rd_val, 32'h8421_7E3D);
    rd(sdmlc_pkg::REG_CSL1);
    cmp(rd_val, 32'h0000_00C1);
    rd(sdmlc_pkg::REG_CSR0);
    cmp(rd_val, 32'h7C5A_9B12);
    rd(sdmlc_pkg::REG_CSR1);
    cmp(rd_val, 32'h0000_003E);
  endtask
  task automatic t_feat();
    wr(sdmlc_pkg::REG_VOL, 32'h0000_3C81);
    cmp({feat.vol_l, feat.vol_r}, 32'h0000_813C);
    wr(sdmlc_pkg::REG_TONE, 32'h0000_00A5);
    cmp({feat.treble, feat.bass}, 32'h0000_00A5);
    for (int i = 0; i < 3; i++) begin
      wr(sdmlc_pkg::REG_FEAT, 32'(i) | (32'(i + 1) << 2) | (32'(i % 2) << 4));
      cmp({feat.filt, feat.deemp, feat.os128}, 32'(i * 8 + (i + 1) * 2 + i % 2));
    end
  endtask
  task automatic t_modes();
    wr(sdmlc_pkg::REG_CLOCK, 32'h0000_0406);
    cmp({route.dac_from_xtal, route.in_slave}, 32'h3);
    strobes = 0;
    run <= 1'b1;
    cyc(2600);
    run <= 1'b0;
    cmp(32'(strobes > 0), 32'h1);
    wr(sdmlc_pkg::REG_CLOCK, 32'h0000_0407);
    cmp({route.dac_from_xtal, route.pll_to_spdif}, 32'h3);
    wr(sdmlc_pkg::REG_CLOCK, 32'h0000_1008);
    xen <= 1'b1;
    cyc(1);
    cmp({route.pll_to_spdif, route.out_data_valid, route.prescale}, 32'h210);
    cmp(32'(xout), 32'h1);
    xen <= 1'b0;
    cyc(1);
    cmp(32'(xout), 32'h0);
  endtask
  task automatic t_ctl();
    for (int k = 0; k < 3; k++) begin
      do_reset(k == 2, k == 0);
      cmp(32'(ctl), 32'(k == 2 ? 2 : 1 - k));
    end
    for (int i = 0; i < 4; i++) begin
      bmode <= i[1];
      bdata <= i[0];
      cyc(4);
      cmp({feat.fmt, feat.deemp}, 32'(i * 4 + 2));
    end
    wr(sdmlc_pkg::REG_CLOCK, 32'h0000_0406);
    cmp(32'(route.dac_from_xtal), 32'h0);
  endtask

  // ==========================================================================
  // main sequence and watchdog
  // ==========================================================================
  initial begin
    {srst, reg_wr, reg_rd, st_sel, i2c_sel, bmode, bdata, mute_pin, run} = '0;
    {pll, dec, pcm, burst, xen, reg_addr, reg_wdata} = '0;
    {csl, csr, smp} = '0;
    err_count = 0;
    n_compared = 0;
    do_reset(1'b0, 1'b0);
    t_lock();
    t_hard();
    t_ramp();
    t_data();
    t_feat();
    t_modes();
    t_ctl();
    wrap_up();
  end
  initial begin
    #400000;
    err_count++;
    $display("[ERR] %0t watchdog expired", $time);
    wrap_up();
  end
endmodule // tb_sdmlc_top
